/* File: dv/pgei_host.sv */
// apb master standing in for the host processor
`timescale 1ns/1ps
module pgei_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rd_data;
  logic rd_err;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  //////////////////////////////////////////
  // request held until the edge that samples pready high
  task automatic xfer(input logic wr, input logic [7:0] idx,
    input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : pgei_host

/* File: dv/pgei_tb_top.sv */
// self-checking bench of the pgei block against an integer model
`timescale 1ns/1ps
`include "pgei_defines.svh"
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      err_total++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module pgei_tb_top;
  localparam int SLOW = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic full_resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pin0_out, pin0_oe, pin0_pulldown, shared_irq_out;
  logic pin0_in = 1'b1;
  logic [5:1] ext_pin_level = 5'h00;
  logic wdog_event = 1'b0;
  logic thermal_reset_input = 1'b0;
  logic comp2_above = 1'b0;
  logic sleep_state = 1'b0;
  logic pin0_in_sequence = 1'b0;
  logic shutdown_reset = 1'b0;
  logic [7:0] rnd = 8'h29;
  logic [9:0] pad_tab [10] = '{10'h000, 10'h014, 10'h010, 10'h094,
    10'h090, 10'h034, 10'h207, 10'h205, 10'h206, 10'h3FC};
  int m_sts [2] = '{0, 0};
  int m_msk [2] = '{255, 255};
  int m_cfg = 0;
  int m_lvl = 1;
  int err_total = 0;
  int checks_done = 0;
  int cyc_n = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc_n++;
  pgei_top #(.SLOW_TICK_CYC(SLOW)) dut (.pclk, .presetn, .full_resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin0_in, .pin0_out, .pin0_oe, .pin0_pulldown,
    .ext_pin_level, .wdog_event, .thermal_reset_input, .comp2_above,
    .sleep_state, .pin0_in_sequence, .shutdown_reset, .shared_irq_out);
  pgei_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  //////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  function automatic logic exp_irq();
    return ((m_sts[0] & ~m_msk[0]) | (m_sts[1] & ~m_msk[1])) != 0;
  endfunction : exp_irq
  function automatic logic [1:0] pad_exp(input int c);
    if (c[7] && pin0_in_sequence && sleep_state)
      return 2'h2;
    if (!c[2] && !pin0_in_sequence)
      return 2'h0;
    if (c[5])
      return {~c[0], 1'b0};
    return {1'b1, c[0]};
  endfunction : pad_exp
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.xfer(1'b1, idx, d);
    case (idx)
      `PGEI_IDX_PIN_STS, `PGEI_IDX_MISC_STS:
        m_sts[(idx - 8'h52) / 2] &= ~int'(d);
      `PGEI_IDX_PIN_MSK, `PGEI_IDX_MISC_MSK:
        m_msk[(idx - 8'h53) / 2] = d;
      default:
        m_cfg = d;
    endcase
  endtask : wr
  task automatic chk_all();
    for (int k = 0; k < 4; k++)
    begin
      host.xfer(1'b0, 8'h52 + 8'(k), 8'h00);
      `CHK("irq reg", 8'(k % 2 ? m_msk[k / 2] : m_sts[k / 2]), host.rd_data[7:0])
    end
    host.xfer(1'b0, `PGEI_IDX_PIN0_CFG, 8'h00);
    `CHK("cfg", 8'((m_cfg & 8'hBD) | (m_lvl << 1)), host.rd_data[7:0])
    `CHK("irq", exp_irq(), shared_irq_out)
  endtask : chk_all
  task automatic chk_pad();
    repeat (3) @(posedge pclk);
    `CHK("pad", pad_exp(m_cfg), {pin0_oe, pin0_oe & pin0_out})
    `CHK("pulldown", m_cfg[3], pin0_pulldown)
    chk_all();
  endtask : chk_pad
  task automatic set_pin(input int p, input logic v);
    @(posedge pclk);
    if (ext_pin_level[p] !== v)
      m_sts[p / 4] |= 1 << ((p % 4) * 2 + (v ? 0 : 1));
    ext_pin_level[p] <= v;
    repeat (3) @(posedge pclk);
  endtask : set_pin
  task automatic misc_evt(input int b);
    @(posedge pclk);
    wdog_event <= (b == 4);
    thermal_reset_input <= (b == 7);
    if (b == 5 || b == 6)
      comp2_above <= (b == 5);
    @(posedge pclk);
    wdog_event <= 1'b0;
    thermal_reset_input <= 1'b0;
    m_sts[1] |= 1 << b;
    repeat (3) @(posedge pclk);
  endtask : misc_evt
  // polls the level bit; the cycle count shows which filter ran
  task automatic wait_lvl(input logic v, input int lo, input int hi);
    int t;
    t = cyc_n;
    for (int i = 0; i < 6000; i++)
    begin
      host.xfer(1'b0, `PGEI_IDX_PIN0_CFG, 8'h00);
      if (host.rd_data[1] === v)
        break;
    end
    t = cyc_n - t;
    `CHK("settle", 1'b1, (t >= lo && t <= hi))
    m_lvl = v;
    m_sts[0] |= v ? 1 : 2;
    chk_all();
  endtask : wait_lvl
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  //////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    full_resetn <= 1'b1;
    chk_all();
    host.xfer(1'b0, 8'h56, 8'h00);
    `CHK("unmapped err", 1'b1, host.rd_err)
    `CHK("unmapped data", 32'h00000000, host.rd_data)
    for (int p = 1; p < 6; p++)
    begin
      set_pin(p, 1'b1);
      set_pin(p, 1'b0);
    end
    foreach (pad_tab[i])
      misc_evt(4 + i % 4);
    chk_all();
    repeat (8)
    begin
      rnd = lfsr_next(rnd);
      misc_evt(rnd[3] ? 7 : 4);
      set_pin(1 + rnd[7:5] % 5, rnd[4]);
      wr(8'h53 + {rnd[0], 1'b0}, rnd);
      chk_all();
      wr(`PGEI_IDX_PIN_STS, 8'h00);
      wr(`PGEI_IDX_MISC_STS, 8'h00);
      chk_all();
      wr(8'h52 + {rnd[1], 1'b0}, lfsr_next(rnd));
      chk_all();
    end
    misc_evt(7);
    wr(`PGEI_IDX_MISC_MSK, 8'h7F);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    m_msk = '{255, 255};
    m_cfg = 0;
    chk_all();
    full_resetn <= 1'b0;
    repeat (2) @(posedge pclk);
    full_resetn <= 1'b1;
    m_sts = '{0, 0};
    chk_all();
    foreach (pad_tab[i])
    begin
      @(posedge pclk);
      pin0_in_sequence <= pad_tab[i][1];
      sleep_state <= pad_tab[i][0];
      wr(`PGEI_IDX_PIN0_CFG, pad_tab[i][9:2]);
      chk_pad();
    end
    pin0_in_sequence <= 1'b1;
    wr(`PGEI_IDX_PIN0_CFG, 8'h05);
    shutdown_reset <= 1'b1;
    @(posedge pclk);
    shutdown_reset <= 1'b0;
    m_cfg |= 8'h20;
    chk_pad();
    pin0_in_sequence <= 1'b0;
    wr(`PGEI_IDX_PIN0_CFG, 8'h00);
    pin0_in <= 1'b0;
    wait_lvl(1'b0, 6000, 12300);
    wr(`PGEI_IDX_PIN0_CFG, 8'h10);
    pin0_in <= 1'b1;
    wait_lvl(1'b1, 30, 120);
    complete_run();
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    err_total++;
    complete_run();
  end
endmodule : pgei_tb_top

/* File: hdl/pgei_defines.svh */
// offsets, field positions, reset values and timing counts of the pgei block
`ifndef PGEI_DEFINES_SVH
`define PGEI_DEFINES_SVH
// register indices; byte address is four times the index
`define PGEI_IDX_PIN_STS 8'h52
`define PGEI_IDX_PIN_MSK 8'h53
`define PGEI_IDX_MISC_STS 8'h54
`define PGEI_IDX_MISC_MSK 8'h55
`define PGEI_IDX_PIN0_CFG 8'h60
// reset values
`define PGEI_STS_RST 8'h00
`define PGEI_MSK_RST 8'hFF
`define PGEI_CFG_RST 8'h00
`define PGEI_LVL_RST 1'h1
// misc status field positions
`define PGEI_MISC_PIN_LSB 0
`define PGEI_MISC_WDOG 4
`define PGEI_MISC_ABOVE 5
`define PGEI_MISC_BELOW 6
`define PGEI_MISC_THERMAL_RESET_INPUT 7
// pin0 configuration field positions
`define PGEI_CFG_SLEEP 7
`define PGEI_CFG_RSVD 6
`define PGEI_CFG_OD 5
`define PGEI_CFG_DEB 4
`define PGEI_CFG_PD 3
`define PGEI_CFG_DIR 2
`define PGEI_CFG_LVL 1
`define PGEI_CFG_VAL 0
// timing
`define PGEI_CLK_PERIOD_NS 10
`define PGEI_FAST_TICK_NS 30500
`define PGEI_SLOW_TICK_MS 50
`define PGEI_DEB_SAMPLES 3
`define PGEI_FAST_TICK_CYC (`PGEI_FAST_TICK_NS / `PGEI_CLK_PERIOD_NS)
`define PGEI_SLOW_TICK_CYC (`PGEI_SLOW_TICK_MS * 1000000 / `PGEI_CLK_PERIOD_NS)
`endif

/* File: hdl/pgei_pkg.sv */
// types shared by the pgei block
package pgei_pkg;
  typedef logic [7:0] pgei_byte_t;
  typedef logic [5:0] pgei_pins_t;
  typedef enum logic [1:0]
  {
    PGEI_PAD_IN = 2'h0,
    PGEI_PAD_PP = 2'h1,
    PGEI_PAD_OD = 2'h3,
    PGEI_PAD_LOW = 2'h2
  } pgei_pad_mode_t;
endpackage : pgei_pkg

/* File: hdl/pgei_top.sv */
// pin event interrupt status/mask pairs and pin0 configuration, apb slave
`timescale 1ns/1ps
`include "pgei_defines.svh"

// Operation
// (R1) event sets status bit, mask ignored
// (R2) write one clears status, zero keeps
// (R3) masked event updates status, no interrupt
// (R4) unmasked event asserts shared interrupt
// (R5) pin status: pins 3..0, fall upper
// (R6) misc status bits 3..0: pins 5,4
// (R7) bit7 powerdown high, bit4 watchdog
// (R8) bit5 comparator above, bit6 below
// (R9) masks mirror status, reset all ones
// (R10) status on full reset, rest general
// (R11) sleep bit forces pin low in sleep
// (R12) sleep bit needs sequence slot; output
// (R13) sleep bit inactive in active mode
// (R14) bit5 selects push-pull or open-drain
// (R15) shutdown reset sets open-drain bit; code sets it only while pin0_in_sequence
// (R16) bit4 picks fast or slow debounce
// (R17) bit3 pulldown enable, resets zero
// (R18) bit2 direction: zero in, one out
// (R19) bit1 reads sampled level, resets one
// (R20) bit0 is level driven as output
// (R21) edge flags from debounced level
// (R22) interrupt holds while unmasked bit set
module pgei_top #(
  parameter int SLOW_TICK_CYC = `PGEI_SLOW_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic full_resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin0_in,
  output logic pin0_out,
  output logic pin0_oe,
  output logic pin0_pulldown,
  input wire logic [5:1] ext_pin_level,
  input wire logic wdog_event,
  input wire logic thermal_reset_input,
  input wire logic comp2_above,
  input wire logic sleep_state,
  input wire logic pin0_in_sequence,
  input wire logic shutdown_reset,
  output logic shared_irq_out
);

  localparam int FAST_TICK_CYC = `PGEI_FAST_TICK_CYC;

  function automatic logic reg_hit(
    input logic [11:0] addr,
    input logic [7:0] idx
  );
    reg_hit = (addr == {2'h0, idx, 2'h0});
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic wr_en, any_hit;
  logic hit_psts, hit_pmsk, hit_msts, hit_mmsk, hit_cfg;
  pgei_pkg::pgei_byte_t wbyte;
  assign wr_en = psel & penable & pwrite & any_hit;
  assign hit_psts = reg_hit(paddr, `PGEI_IDX_PIN_STS);
  assign hit_pmsk = reg_hit(paddr, `PGEI_IDX_PIN_MSK);
  assign hit_msts = reg_hit(paddr, `PGEI_IDX_MISC_STS);
  assign hit_mmsk = reg_hit(paddr, `PGEI_IDX_MISC_MSK);
  assign hit_cfg = reg_hit(paddr, `PGEI_IDX_PIN0_CFG);
  assign any_hit = hit_psts | hit_pmsk | hit_msts | hit_mmsk | hit_cfg;
  assign wbyte = pwdata[7:0];
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~any_hit;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  pgei_pkg::pgei_byte_t psts_ff, msts_ff, pmsk_ff, mmsk_ff, cfg_ff;
  pgei_pkg::pgei_byte_t nxt_psts, nxt_msts, pset, mset;
  logic lvl0_ff;
  logic [31:0] prdata_ff;
  // masks and configuration live in the general reset domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pmsk_ff <= `PGEI_MSK_RST; // R9 R10
      mmsk_ff <= `PGEI_MSK_RST; // R9
    end
    else
    begin
      if (wr_en && hit_pmsk)
        pmsk_ff <= wbyte;
      if (wr_en && hit_mmsk)
        mmsk_ff <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_ff <= `PGEI_CFG_RST; // R10 R17
    else
    begin
      if (wr_en && hit_cfg)
      begin
        cfg_ff <= wbyte;
        cfg_ff[`PGEI_CFG_RSVD] <= 1'b0;
        cfg_ff[`PGEI_CFG_LVL] <= 1'b0;
      end
      // a shutdown reset while pin0_in_sequence wins over a write of bit5 in the same cycle
      if (shutdown_reset && pin0_in_sequence)
        cfg_ff[`PGEI_CFG_OD] <= 1'b1; // R15
    end
  end

  // set wins over clear so no event is lost
  always_comb
  begin
    nxt_psts = (psts_ff & ~((wr_en && hit_psts) ? wbyte : 8'h00)) | pset; // R1 R2
    nxt_msts = (msts_ff & ~((wr_en && hit_msts) ? wbyte : 8'h00)) | mset; // R1 R2
  end

  // status bits survive a general reset, only full reset clears them
  always_ff @(posedge pclk or negedge full_resetn)
  begin
    if (!full_resetn)
    begin
      psts_ff <= `PGEI_STS_RST; // R10
      msts_ff <= `PGEI_STS_RST; // R10
    end
    else
    begin
      psts_ff <= nxt_psts;
      msts_ff <= nxt_msts;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0;
    else if (psel && !penable)
    begin
      prdata_ff <= 32'h0;
      if (hit_psts)
        prdata_ff[7:0] <= psts_ff;
      if (hit_pmsk)
        prdata_ff[7:0] <= pmsk_ff;
      if (hit_msts)
        prdata_ff[7:0] <= msts_ff;
      if (hit_mmsk)
        prdata_ff[7:0] <= mmsk_ff;
      if (hit_cfg)
      begin
        prdata_ff[7:0] <= cfg_ff;
        prdata_ff[`PGEI_CFG_LVL] <= lvl0_ff; // R19
      end
    end
  end
  assign prdata = prdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // pin0 debounce: three equal samples at the selected tick rate
  logic [31:0] tick_cnt_ff, tick_lim;
  logic tick;
  logic [2:0] samp_ff;
  assign tick_lim = cfg_ff[`PGEI_CFG_DEB] ? 32'(SLOW_TICK_CYC - 1)
                                          : 32'(FAST_TICK_CYC - 1); // R16
  assign tick = (tick_cnt_ff >= tick_lim);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_ff <= 32'h0;
    else if (tick)
      tick_cnt_ff <= 32'h0;
    else
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      samp_ff <= 3'h7;
      lvl0_ff <= `PGEI_LVL_RST; // R19
    end
    else if (tick)
    begin
      samp_ff <= {samp_ff[1:0], pin0_in};
      if ({samp_ff[1:0], pin0_in} == 3'h7)
        lvl0_ff <= 1'b1; // R16
      else if ({samp_ff[1:0], pin0_in} == 3'h0)
        lvl0_ff <= 1'b0; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events
  pgei_pkg::pgei_pins_t lvl, prev_ff, rise, fall;
  logic armed_ff, comp_prev_ff;
  assign lvl = {ext_pin_level, lvl0_ff};
  // first cycle after reset only loads history, so no false edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_ff <= 6'h3F;
      comp_prev_ff <= 1'b0;
      armed_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= lvl;
      comp_prev_ff <= comp2_above;
      armed_ff <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_edge
      assign rise[gi] = armed_ff & lvl[gi] & ~prev_ff[gi]; // R21
      assign fall[gi] = armed_ff & ~lvl[gi] & prev_ff[gi]; // R21
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_pset
      assign pset[2 * gi] = rise[gi]; // R5
      assign pset[2 * gi + 1] = fall[gi]; // R5
    end
    for (gi = 0; gi < 2; gi++)
    begin : g_mset
      assign mset[2 * gi] = rise[gi + 4]; // R6
      assign mset[2 * gi + 1] = fall[gi + 4]; // R6
    end
  endgenerate

  assign mset[`PGEI_MISC_WDOG] = wdog_event; // R7
  assign mset[`PGEI_MISC_THERMAL_RESET_INPUT] = thermal_reset_input; // R7
  assign mset[`PGEI_MISC_ABOVE] = armed_ff & comp2_above
                                  & ~comp_prev_ff; // R8
  assign mset[`PGEI_MISC_BELOW] = armed_ff & ~comp2_above
                                  & comp_prev_ff; // R8

  ////////////////////////////////////////////////////////////////////////////
  // shared interrupt
  logic irq_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |((psts_ff & ~pmsk_ff) | (msts_ff & ~mmsk_ff)); // R3 R4 R22
  end
  assign shared_irq_out = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // pin0 pad
  pgei_pkg::pgei_pad_mode_t mode;
  logic force_low, as_out, out_ff, oe_ff, pd_ff;
  // sleep forcing only for a sequenced pin, and only in sleep
  assign force_low = cfg_ff[`PGEI_CFG_SLEEP] & pin0_in_sequence
                     & sleep_state; // R11 R12 R13
  assign as_out = cfg_ff[`PGEI_CFG_DIR] | pin0_in_sequence; // R12 R18

  always_comb
  begin
    if (force_low)
      mode = pgei_pkg::PGEI_PAD_LOW; // R11
    else if (!as_out)
      mode = pgei_pkg::PGEI_PAD_IN; // R18
    else if (cfg_ff[`PGEI_CFG_OD])
      mode = pgei_pkg::PGEI_PAD_OD; // R14
    else
      mode = pgei_pkg::PGEI_PAD_PP; // R14
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
      pd_ff <= 1'b0;
    end
    else
    begin
      pd_ff <= cfg_ff[`PGEI_CFG_PD]; // R17
      // open drain only releases, so it never drives a high level
      out_ff <= (mode == pgei_pkg::PGEI_PAD_PP)
                & cfg_ff[`PGEI_CFG_VAL]; // R20
      oe_ff <= (mode == pgei_pkg::PGEI_PAD_LOW)
               | (mode == pgei_pkg::PGEI_PAD_PP)
               | ((mode == pgei_pkg::PGEI_PAD_OD)
                  & ~cfg_ff[`PGEI_CFG_VAL]); // R20
    end
  end
  assign pin0_out = out_ff;
  assign pin0_oe = oe_ff;
  assign pin0_pulldown = pd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // event, then a cycle with no status write that could clear it
  sequence s_ev_no_clr(int b);
    mset[b] ##1 !(wr_en && hit_msts);
  endsequence

  property p_set_wins;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    pset[0] |=> psts_ff[0];
  endproperty
  a_set_wins: assert property (p_set_wins) // R1
    else $error("edge event did not set status");
  property p_w1c;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    (wr_en && hit_psts && wbyte[3] && !pset[3]) |=> !psts_ff[3];
  endproperty
  a_w1c: assert property (p_w1c) // R2
    else $error("write one did not clear status");
  property p_w0_keep;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    (wr_en && hit_msts && !wbyte[4] && msts_ff[4]) |=> msts_ff[4];
  endproperty
  a_w0_keep: assert property (p_w0_keep) // R2
    else $error("write zero changed status");
  property p_masked;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    ((psts_ff & ~pmsk_ff) == 8'h00 && (msts_ff & ~mmsk_ff) == 8'h00)
      |=> !shared_irq_out;
  endproperty
  a_masked: assert property (p_masked) // R3
    else $error("interrupt raised with all events masked");
  property p_unmasked;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    ((psts_ff & ~pmsk_ff) | (msts_ff & ~mmsk_ff)) != 8'h00
      |=> shared_irq_out;
  endproperty
  a_unmasked: assert property (p_unmasked) // R4 R22
    else $error("unmasked status did not raise interrupt");
  property p_thermal_reset_input;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    thermal_reset_input |=> msts_ff[`PGEI_MISC_THERMAL_RESET_INPUT];
  endproperty
  a_thermal_reset_input: assert property (p_thermal_reset_input) // R7
    else $error("powerdown level not flagged");
  property p_below;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    s_ev_no_clr(`PGEI_MISC_BELOW) |-> msts_ff[`PGEI_MISC_BELOW] [*2];
  endproperty
  a_below: assert property (p_below) // R8
    else $error("below threshold flag not held");
  property p_sleep_low;
    @(posedge pclk) disable iff (!presetn)
    (cfg_ff[`PGEI_CFG_SLEEP] && pin0_in_sequence && sleep_state)
      |=> (pin0_oe && !pin0_out);
  endproperty
  a_sleep_low: assert property (p_sleep_low) // R11 R12
    else $error("sleep forcing did not drive low");
  property p_active;
    @(posedge pclk) disable iff (!presetn)
    (!sleep_state && !cfg_ff[`PGEI_CFG_DIR] && !pin0_in_sequence)
      |=> !pin0_oe;
  endproperty
  a_active: assert property (p_active) // R13 R18
    else $error("pad driven while input in active mode");
  property p_od;
    @(posedge pclk) disable iff (!presetn)
    (!force_low && as_out && cfg_ff[`PGEI_CFG_OD]
     && cfg_ff[`PGEI_CFG_VAL]) |=> !pin0_oe;
  endproperty
  a_od: assert property (p_od) // R14 R20
    else $error("open drain drove a high level");
  property p_shutdown;
    @(posedge pclk) disable iff (!presetn)
    (shutdown_reset && pin0_in_sequence) |=> cfg_ff[`PGEI_CFG_OD];
  endproperty
  a_shutdown: assert property (p_shutdown) // R15
    else $error("shutdown did not select open drain");
  property p_edge;
    @(posedge pclk) disable iff (!full_resetn || !presetn)
    (armed_ff && lvl[4] && !prev_ff[4]) |=> msts_ff[0];
  endproperty
  a_edge: assert property (p_edge) // R21
    else $error("rising level not flagged");

endmodule : pgei_top
